// File: ffr_consts.svh
`ifndef FFR_CONSTS_SVH
`define FFR_CONSTS_SVH
`define FFR_ADDR_REC_A 16'hFECA
`define FFR_ADDR_REC_B 16'hFECB
`define FFR_ADDR_CFG 16'hFE08
`define FFR_ADDR_KEY 16'h00D6
`define FFR_CFG_REC_EN_BIT 5
`define FFR_CFG_RST 8'h00
`define FFR_KEY_DEFAULT 8'hFF
`define FFR_REC_RST 8'h00
`define FFR_NUM_FLAGS 15
`define FFR_TRIM_LO 16'hFE10
`define FFR_TRIM_HI 16'hFE17
`define FFR_TRIM_1C 16'hFE1C
`define FFR_TRIM_1D 16'hFE1D
`define FFR_TRIM_6E 16'hFE6E
`define FFR_TRIM_73 16'hFE73
`define FFR_TRIM_74 16'hFE74
`define FFR_TRIM_77 16'hFE77
`define FFR_TRIM_7C 16'hFE7C
`define FFR_TRIM_7F 16'hFE7F
`endif

// File: ffr_pkg.sv
package ffr_pkg;
  `include "ffr_consts.svh"

  typedef enum logic [1:0] {ACT_IGNORE, ACT_DIS_A, ACT_DIS_B, ACT_DIS_ALL}
    ffr_act_t;
  typedef enum logic [1:0] {RES_IMMED, RES_SOFT, RES_LATCH, RES_RSVD}
    ffr_res_t;
  typedef enum logic [1:0] {LK_LOCKED, LK_HALF, LK_OPEN} ffr_lock_t;
  typedef logic [3:0] ffr_id_t;

  function automatic logic ffr_disables(ffr_act_t act, logic chan_b);
    return (act == ACT_DIS_ALL) ||
           (chan_b ? (act == ACT_DIS_B) : (act == ACT_DIS_A));
  endfunction

  function automatic logic ffr_is_trim(logic [15:0] addr);
    return ((addr >= `FFR_TRIM_LO) && (addr <= `FFR_TRIM_HI)) ||
           (addr == `FFR_TRIM_1C) || (addr == `FFR_TRIM_1D) ||
           (addr == `FFR_TRIM_6E) || (addr == `FFR_TRIM_73) ||
           (addr == `FFR_TRIM_74) || (addr == `FFR_TRIM_77) ||
           ((addr >= `FFR_TRIM_7C) && (addr <= `FFR_TRIM_7F));
  endfunction
endpackage

// File: ffr_chan_if.sv
`timescale 1ns/1ps
interface ffr_chan_if;
  import ffr_pkg::*;
  logic hit;
  ffr_id_t hit_id;
  logic rec_en;
  logic chan_on;
  logic pon_load;
  ffr_id_t nv_id;
  logic rd_clr;
  logic [7:0] rec;
  logic nv_req;
  modport ctl (output hit, hit_id, rec_en, chan_on, pon_load, nv_id, rd_clr,
               input rec, nv_req);
  modport chan (input hit, hit_id, rec_en, chan_on, pon_load, nv_id, rd_clr,
                output rec, nv_req);
endinterface

// File: ffr_chan.sv
`timescale 1ns/1ps
`include "ffr_consts.svh"
module ffr_chan
  import ffr_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  ffr_chan_if.chan cif
);
  logic [7:0] rec_r, rec_nxt;
  logic tripped_r, tripped_nxt;
  logic on_q_r, on_q_nxt;
  logic nv_req_r, nv_req_nxt;
  logic restart, qual;

  assign cif.rec = rec_r;
  assign cif.nv_req = nv_req_r;
  // A fresh turn-on re-arms; blocks faults seen while already off
  assign restart = cif.chan_on & ~on_q_r;
  assign qual = cif.rec_en & cif.chan_on & cif.hit &
                (~tripped_r | restart);

  always_comb
  begin
    rec_nxt = rec_r;
    tripped_nxt = tripped_r & ~restart;
    on_q_nxt = cif.chan_on;
    nv_req_nxt = 1'b0;
    if (qual)
    begin
      // Current moves to previous (high nibble), new id to current
      rec_nxt = {rec_r[3:0], cif.hit_id};
      tripped_nxt = 1'b1;
      nv_req_nxt = 1'b1;
    end
    else if (cif.pon_load)
      rec_nxt = {cif.nv_id, cif.nv_id};
    else if (cif.rd_clr)
      rec_nxt = `FFR_REC_RST;
  end

  always_ff @(posedge ref_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      rec_r <= `FFR_REC_RST;
      tripped_r <= 1'b0;
      on_q_r <= 1'b0;
      nv_req_r <= 1'b0;
    end
    else
    begin
      rec_r <= rec_nxt;
      tripped_r <= tripped_nxt;
      on_q_r <= on_q_nxt;
      nv_req_r <= nv_req_nxt;
    end
  end

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);

  sequence s_fault_on;
    cif.rec_en && cif.chan_on && cif.hit && !tripped_r;
  endsequence
  sequence s_shifted;
    rec_r == {$past(rec_r[3:0]), $past(cif.hit_id)} && nv_req_r;
  endsequence

  a_rec_shift_in: assert property (s_fault_on |=> s_shifted)
    else $error("record not shifted on qualifying fault");
  a_off_no_update: assert property (
    (tripped_r && !restart && !cif.pon_load && !cif.rd_clr)
      |=> $stable(rec_r) && !nv_req_r)
    else $error("record changed while channel already off");
  a_disabled_hold: assert property (
    (!cif.rec_en && !cif.pon_load && !cif.rd_clr) |=> $stable(rec_r))
    else $error("record changed while recording disabled");
  a_pon_load_both: assert property (
    (cif.pon_load && !qual) |=> rec_r == {2{$past(cif.nv_id)}})
    else $error("power-on load did not fill both fields");
  a_hold_unread: assert property (
    (!qual && !cif.pon_load && !cif.rd_clr) |=> $stable(rec_r))
    else $error("record lost without a read");
endmodule // ffr_chan

// File: ffr_top.sv
`timescale 1ns/1ps
`include "ffr_consts.svh"
// Notes on behaviour
// - Separate record per channel, consecutive addresses
// - Record only first shutdown-with-soft-start flag
// - Ignored flags never recorded
// - No-soft-start shutdown flags never recorded
// - Record holds current and previous identity
// - Record kept until software reads it
// - Enable bit set: records copied to storage
// - Enable bit clear: recording off, faults leave records unchanged
// - Power-on request loads stored id into both
// - Qualifying fault shifts record, then stores it
// - Faults while already off change nothing
// - Flag clears and auto restart leave record
// - Trim locked until key written twice
// - Lock covers the listed trim addresses
// - Action disables A, B or all outputs
module ffr_top
  import ffr_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire logic [14:0] flag_in,
  input wire logic [29:0] flag_act_in,
  input wire logic [29:0] flag_res_in,
  input wire logic [1:0] chan_on_in,
  input wire logic [1:0] power_on_request_in,
  input wire logic [7:0] nv_rec_a_in,
  input wire logic [7:0] nv_rec_b_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [15:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  output logic nv_wr_out,
  output logic nv_wr_chan_out,
  output logic [7:0] nv_wr_data_out,
  output logic trim_wr_out,
  output logic [15:0] trim_addr_out,
  output logic [7:0] trim_data_out,
  output logic trim_unlocked_out,
  output logic rec_en_out
);
  logic [7:0] cfg_r, cfg_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic [1:0] pon_q_r, pon_q_nxt;
  logic [1:0] pend_r, pend_nxt;
  logic nv_wr_r, nv_wr_nxt;
  logic nv_chan_r, nv_chan_nxt;
  logic [7:0] nv_data_r, nv_data_nxt;
  ffr_lock_t lock_r, lock_nxt;
  logic unlocked_r, unlocked_nxt;
  logic trim_wr_r, trim_wr_nxt;
  logic [15:0] trim_addr_r, trim_addr_nxt;
  logic [7:0] trim_data_r, trim_data_nxt;
  logic [1:0] hit_w;
  ffr_id_t hit_id_w [2];
  logic [7:0] rec_w [2];
  logic [1:0] nv_req_w;
  logic key_wr;

  function automatic ffr_act_t act_of(int i);
    return ffr_act_t'(flag_act_in[2*i +: 2]);
  endfunction

  function automatic ffr_res_t res_of(int i);
    return ffr_res_t'(flag_res_in[2*i +: 2]);
  endfunction

  assign key_wr = reg_wr_in && (reg_addr_in == `FFR_ADDR_KEY);

  for (genvar c = 0; c < 2; c++)
  begin : g_ch
    ffr_chan_if cif ();
    logic hit_c;
    ffr_id_t id_c;

    // Lowest index wins when several flags rise in the same cycle
    always_comb
    begin
      hit_c = 1'b0;
      id_c = '0;
      for (int i = `FFR_NUM_FLAGS - 1; i >= 0; i--)
      begin
        if (flag_in[i] && ffr_disables(act_of(i), (c == 1)) &&
            res_of(i) == RES_SOFT)
        begin
          hit_c = 1'b1;
          id_c = ffr_id_t'(i + 1);
        end
      end
    end

    assign cif.hit = hit_c;
    assign cif.hit_id = id_c;
    assign cif.rec_en = cfg_r[`FFR_CFG_REC_EN_BIT];
    assign cif.chan_on = chan_on_in[c];
    assign cif.pon_load = power_on_request_in[c] & ~pon_q_r[c];
    assign cif.nv_id = (c == 0) ? nv_rec_a_in[3:0] : nv_rec_b_in[3:0];
    assign cif.rd_clr = reg_rd_in &&
      (reg_addr_in == ((c == 0) ? `FFR_ADDR_REC_A : `FFR_ADDR_REC_B));
    assign hit_w[c] = hit_c;
    assign hit_id_w[c] = id_c;
    assign rec_w[c] = cif.rec;
    assign nv_req_w[c] = cif.nv_req;

    ffr_chan u_chan (
      .ref_clk_in(ref_clk_in),
      .sys_rst_in(sys_rst_in),
      .cif(cif.chan)
    );

    for (genvar i = 0; i < `FFR_NUM_FLAGS; i++)
    begin : g_fl
      a_ignore_skip: assert property (@(posedge ref_clk_in)
        disable iff (sys_rst_in)
        (hit_w[c] && act_of(i) == ACT_IGNORE)
          |-> hit_id_w[c] != ffr_id_t'(i + 1))
        else $error("ignored flag selected for record");
      a_nosoft_skip: assert property (@(posedge ref_clk_in)
        disable iff (sys_rst_in)
        (hit_w[c] && res_of(i) != RES_SOFT)
          |-> hit_id_w[c] != ffr_id_t'(i + 1))
        else $error("flag without soft start selected for record");
    end
  end

  // Register port: config write, config and record reads; key reads as zero
  always_comb
  begin
    cfg_nxt = cfg_r;
    rdata_nxt = rdata_r;
    pon_q_nxt = power_on_request_in;
    if (reg_wr_in && reg_addr_in == `FFR_ADDR_CFG)
      cfg_nxt = reg_wdata_in;
    if (reg_rd_in)
    begin
      case (reg_addr_in)
        `FFR_ADDR_REC_A: rdata_nxt = rec_w[0];
        `FFR_ADDR_REC_B: rdata_nxt = rec_w[1];
        `FFR_ADDR_CFG: rdata_nxt = cfg_r;
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      cfg_r <= `FFR_CFG_RST;
      rdata_r <= 8'h00;
      pon_q_r <= 2'b00;
    end
    else
    begin
      cfg_r <= cfg_nxt;
      rdata_r <= rdata_nxt;
      pon_q_r <= pon_q_nxt;
    end
  end

  // Storage writes: one per cycle, channel A first; a request that
  // lands while its own is being served stays pending
  always_comb
  begin
    pend_nxt = pend_r;
    nv_wr_nxt = 1'b0;
    nv_chan_nxt = nv_chan_r;
    nv_data_nxt = nv_data_r;
    if (pend_r[0])
    begin
      nv_wr_nxt = 1'b1;
      nv_chan_nxt = 1'b0;
      nv_data_nxt = rec_w[0];
      pend_nxt[0] = 1'b0;
    end
    else if (pend_r[1])
    begin
      nv_wr_nxt = 1'b1;
      nv_chan_nxt = 1'b1;
      nv_data_nxt = rec_w[1];
      pend_nxt[1] = 1'b0;
    end
    pend_nxt = pend_nxt | nv_req_w;
  end

  always_ff @(posedge ref_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      pend_r <= 2'b00;
      nv_wr_r <= 1'b0;
      nv_chan_r <= 1'b0;
      nv_data_r <= 8'h00;
    end
    else
    begin
      pend_r <= pend_nxt;
      nv_wr_r <= nv_wr_nxt;
      nv_chan_r <= nv_chan_nxt;
      nv_data_r <= nv_data_nxt;
    end
  end

  // Trim key: two matching writes in a row open; a wrong key relocks
  always_comb
  begin
    lock_nxt = lock_r;
    if (key_wr)
    begin
      if (reg_wdata_in != `FFR_KEY_DEFAULT)
        lock_nxt = LK_LOCKED;
      else
      begin
        case (lock_r)
          LK_LOCKED: lock_nxt = LK_HALF;
          LK_HALF: lock_nxt = LK_OPEN;
          LK_OPEN: lock_nxt = LK_OPEN;
          default: lock_nxt = LK_LOCKED;
        endcase
      end
    end
    unlocked_nxt = (lock_nxt == LK_OPEN);
    trim_wr_nxt = reg_wr_in && ffr_is_trim(reg_addr_in) && unlocked_r;
    trim_addr_nxt = trim_wr_nxt ? reg_addr_in : trim_addr_r;
    trim_data_nxt = trim_wr_nxt ? reg_wdata_in : trim_data_r;
  end

  always_ff @(posedge ref_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      lock_r <= LK_LOCKED;
      unlocked_r <= 1'b0;
      trim_wr_r <= 1'b0;
      trim_addr_r <= 16'h0000;
      trim_data_r <= 8'h00;
    end
    else
    begin
      lock_r <= lock_nxt;
      unlocked_r <= unlocked_nxt;
      trim_wr_r <= trim_wr_nxt;
      trim_addr_r <= trim_addr_nxt;
      trim_data_r <= trim_data_nxt;
    end
  end

  assign reg_rdata_out = rdata_r;
  assign nv_wr_out = nv_wr_r;
  assign nv_wr_chan_out = nv_chan_r;
  assign nv_wr_data_out = nv_data_r;
  assign trim_wr_out = trim_wr_r;
  assign trim_addr_out = trim_addr_r;
  assign trim_data_out = trim_data_r;
  assign trim_unlocked_out = unlocked_r;
  assign rec_en_out = cfg_r[`FFR_CFG_REC_EN_BIT];

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);

  sequence s_key_ok;
    key_wr && reg_wdata_in == `FFR_KEY_DEFAULT;
  endsequence
  sequence s_key_first;
    (lock_r == LK_LOCKED) ##0 s_key_ok;
  endsequence
  sequence s_key_second;
    (lock_r == LK_HALF) ##0 s_key_ok;
  endsequence

  a_trim_locked: assert property (
    (reg_wr_in && ffr_is_trim(reg_addr_in) && !unlocked_r) |=> !trim_wr_r)
    else $error("locked trim write passed");
  a_unlock_twice: assert property (s_key_second |=> unlocked_r)
    else $error("two key writes did not unlock");
  a_one_key_locked: assert property (s_key_first |=> !unlocked_r)
    else $error("single key write unlocked trim");
  a_one_key_half: assert property (
    s_key_first |=> lock_r == LK_HALF)
    else $error("first key write did not arm the lock");
  a_bad_key_relock: assert property (
    (key_wr && reg_wdata_in != `FFR_KEY_DEFAULT) |=> !unlocked_r)
    else $error("wrong key left trim unlocked");
  a_trim_only_list: assert property (
    (reg_wr_in && !ffr_is_trim(reg_addr_in)) |=> !trim_wr_r)
    else $error("non-trim write forwarded");
  a_nv_follows: assert property (
    $rose(nv_req_w[0]) |-> ##[1:2] (nv_wr_r && !nv_chan_r))
    else $error("record not stored after update");
  a_nv_data_a: assert property (
    (nv_wr_r && !nv_chan_r) |-> nv_data_r == $past(rec_w[0]))
    else $error("channel A store carried wrong record");
  a_nv_data_b: assert property (
    (nv_wr_r && nv_chan_r) |-> nv_data_r == $past(rec_w[1]))
    else $error("channel B store carried wrong record");
  a_rec_read_a: assert property (
    (reg_rd_in && reg_addr_in == `FFR_ADDR_REC_A)
      |=> reg_rdata_out == $past(rec_w[0]))
    else $error("channel A record read wrong");
  a_rec_read_b: assert property (
    (reg_rd_in && reg_addr_in == `FFR_ADDR_REC_B)
      |=> reg_rdata_out == $past(rec_w[1]))
    else $error("channel B record read wrong");
  a_rdata_hold: assert property (
    !reg_rd_in |=> $stable(reg_rdata_out))
    else $error("read data changed without a read");
endmodule // ffr_top

// File: ffr_far_model.sv
`timescale 1ns/1ps
module ffr_far_model
#(
  parameter logic [7:0] NV_A_INIT = 8'h05,
  parameter logic [7:0] NV_B_INIT = 8'h0c
)
(
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire logic [14:0] flag_in,
  input wire logic [29:0] flag_act_in,
  input wire logic [1:0] power_on_request_in,
  input wire logic nv_wr_in,
  input wire logic nv_wr_chan_in,
  input wire logic [7:0] nv_wr_data_in,
  output logic [1:0] chan_on_out,
  output logic [7:0] nv_rec_a_out,
  output logic [7:0] nv_rec_b_out
);
  logic [1:0] off_r;
  logic [1:0] off_nxt;
  logic [7:0] nv_a_r = NV_A_INIT;
  logic [7:0] nv_a_nxt;
  logic [7:0] nv_b_r = NV_B_INIT;
  logic [7:0] nv_b_nxt;

  // Reenable delay collapsed: outputs return the cycle after the flags that disable them clear
  always_comb
  begin
    off_nxt = 2'b00;
    nv_a_nxt = nv_a_r;
    nv_b_nxt = nv_b_r;
    for (int i = 0; i < 15; i++)
    begin
      if (flag_in[i] && flag_act_in[2*i] ) off_nxt[0] = 1'b1;
      if (flag_in[i] && flag_act_in[2*i+1]) off_nxt[1] = 1'b1;
    end
    if (nv_wr_in && !nv_wr_chan_in) nv_a_nxt = nv_wr_data_in;
    if (nv_wr_in && nv_wr_chan_in) nv_b_nxt = nv_wr_data_in;
  end

  // Stored records survive reset, as storage would survive power loss
  always_ff @(posedge ref_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      off_r <= 2'b00;
    end
    else
    begin
      off_r <= off_nxt;
      nv_a_r <= nv_a_nxt;
      nv_b_r <= nv_b_nxt;
    end
  end

  assign chan_on_out = power_on_request_in & ~off_r;
  assign nv_rec_a_out = nv_a_r;
  assign nv_rec_b_out = nv_b_r;
endmodule // ffr_far_model

// File: ffr_top_tb.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) \
  begin check_count++; if ((g) !== (e)) begin n_fail++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end
module ffr_top_tb;
  logic ref_clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic [14:0] flag = 15'h0000;
  // Flags 0..4: ignore, A immediate, A latched, all soft, B soft
  logic [29:0] act = 30'h0000_02d4;
  logic [29:0] res = 30'h0000_0161;
  logic [1:0] pon = 2'b00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wdata = 8'h00;
  logic [1:0] chan_on;
  logic [7:0] nva;
  logic [7:0] nvb;
  logic [7:0] rdata;
  logic [7:0] nvwd;
  logic [7:0] tdata;
  logic [15:0] taddr;
  logic nvw;
  logic nvch;
  logic tw;
  logic tunl;
  logic recen;
  int n_fail = 0;
  int check_count = 0;
  int n_nv = 0;
  int n_trim = 0;
  int cyc = 0;
  logic [15:0] trims [18] = '{16'hfe10, 16'hfe11, 16'hfe12, 16'hfe13,
    16'hfe14, 16'hfe15, 16'hfe16, 16'hfe17, 16'hfe1c, 16'hfe1d, 16'hfe6e,
    16'hfe73, 16'hfe74, 16'hfe77, 16'hfe7c, 16'hfe7d, 16'hfe7e, 16'hfe7f};

  ffr_top i_dut (
    .ref_clk_in(ref_clk_in),
    .sys_rst_in(sys_rst_in),
    .flag_in(flag),
    .flag_act_in(act),
    .flag_res_in(res),
    .chan_on_in(chan_on),
    .power_on_request_in(pon),
    .nv_rec_a_in(nva),
    .nv_rec_b_in(nvb),
    .reg_wr_in(wr),
    .reg_rd_in(rd),
    .reg_addr_in(addr),
    .reg_wdata_in(wdata),
    .reg_rdata_out(rdata),
    .nv_wr_out(nvw),
    .nv_wr_chan_out(nvch),
    .nv_wr_data_out(nvwd),
    .trim_wr_out(tw),
    .trim_addr_out(taddr),
    .trim_data_out(tdata),
    .trim_unlocked_out(tunl),
    .rec_en_out(recen)
  );

  ffr_far_model i_far (
    .ref_clk_in(ref_clk_in),
    .sys_rst_in(sys_rst_in),
    .flag_in(flag),
    .flag_act_in(act),
    .power_on_request_in(pon),
    .nv_wr_in(nvw),
    .nv_wr_chan_in(nvch),
    .nv_wr_data_in(nvwd),
    .chan_on_out(chan_on),
    .nv_rec_a_out(nva),
    .nv_rec_b_out(nvb)
  );

  always #4 ref_clk_in = ~ref_clk_in;

  task automatic complete_run();
    $display("Checks %0d, errors %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  always @(posedge ref_clk_in)
  begin
    cyc++;
    if (nvw === 1'b1) n_nv++;
    if (tw === 1'b1) n_trim++;
    if (cyc == 3000)
    begin
      n_fail++;
      complete_run();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_in);
    #1;
  endtask

  // Idle cycle after each strobe keeps back-to-back calls race free
  task automatic reg_wr(input logic [15:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    wr = 1'b1;
    tick(1);
    wr = 1'b0;
    tick(1);
  endtask

  task automatic reg_rd(input logic [15:0] a, input logic [7:0] e);
    addr = a;
    rd = 1'b1;
    tick(1);
    rd = 1'b0;
    tick(1);
    `CHK("read data", e, rdata)
  endtask

  initial
  begin
    tick(8);
    sys_rst_in = 1'b0;
    tick(1);
    `CHK("record enable", 1'b0, recen)
    `CHK("trim unlocked", 1'b0, tunl)
    reg_rd(16'hfe08, 8'h00);
    pon = 2'b11;
    tick(2);
    flag = 15'h0008;
    tick(4);
    flag = 15'h0000;
    tick(4);
    `CHK("nv writes", 0, n_nv)
    reg_rd(16'hfeca, 8'h55);
    reg_wr(16'hfe08, 8'h20);
    `CHK("record enable", 1'b1, recen)
    reg_rd(16'hfe08, 8'h20);
    flag = 15'h0006;
    tick(4);
    flag = 15'h0000;
    tick(4);
    `CHK("nv writes", 0, n_nv)
    flag = 15'h0009;
    tick(6);
    `CHK("nv writes", 2, n_nv)
    `CHK("stored a", 8'h04, nva)
    `CHK("stored b", 8'hc4, nvb)
    flag = 15'h0019;
    tick(3);
    flag = 15'h0010;
    tick(3);
    flag = 15'h0000;
    tick(4);
    `CHK("nv writes", 2, n_nv)
    reg_rd(16'hfecb, 8'hc4);
    reg_rd(16'hfecb, 8'h00);
    reg_rd(16'hfeca, 8'h04);
    flag = 15'h0010;
    tick(5);
    `CHK("stored b", 8'h05, nvb)
    reg_rd(16'hfeca, 8'h00);
    flag = 15'h0000;
    pon = 2'b10;
    tick(2);
    pon = 2'b11;
    tick(2);
    reg_rd(16'hfeca, 8'h44);
    reg_wr(16'hfe10, 8'h5a);
    reg_wr(16'h00d6, 8'hff);
    reg_wr(16'hfe11, 8'h5a);
    `CHK("trim writes", 0, n_trim)
    reg_wr(16'h00d6, 8'hff);
    `CHK("trim unlocked", 1'b1, tunl)
    foreach (trims[i])
    begin
      reg_wr(trims[i], 8'(i));
      `CHK("trim address", trims[i], taddr)
      `CHK("trim data", 8'(i), tdata)
    end
    `CHK("trim writes", 18, n_trim)
    reg_wr(16'hfe18, 8'h11);
    reg_wr(16'hfe7b, 8'h11);
    `CHK("trim writes", 18, n_trim)
    reg_rd(16'h00d6, 8'h00);
    reg_rd(16'hfe30, 8'h00);
    reg_wr(16'h00d6, 8'h00);
    `CHK("trim unlocked", 1'b0, tunl)
    complete_run();
  end
endmodule // ffr_top_tb
